// ==== core/pbfs_pkg.sv ====
// Shared constants and types for the port and bus pin function selector.
package pbfs_pkg;

  // ----------------------------------------------------------------------
  // Port geometry
  // ----------------------------------------------------------------------
  localparam int PORT_W = 8;                  // Pins in each port.
  localparam int NPORT  = 3;                  // Ports zero, one and two.
  localparam int PINS   = PORT_W * NPORT;     // All port pins.
  localparam int NSYNC  = PINS + 3;           // Pins, two straps, reset pin.
  localparam int IRQ_LSB = 5;                 // First interrupt-capable bit.
  localparam int NIRQ    = 3;                 // Interrupt-capable bits.
  localparam int NPULL   = NPORT * 2;         // Four-bit pull-up groups.

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_DIR0 = 8'h00;    // Port zero direction.
  localparam logic [7:0] OFS_DIR1 = 8'h04;    // Port one direction.
  localparam logic [7:0] OFS_DIR2 = 8'h08;    // Port two direction.
  localparam logic [7:0] OFS_OUT0 = 8'h0c;    // Port zero output latch.
  localparam logic [7:0] OFS_OUT1 = 8'h10;    // Port one output latch.
  localparam logic [7:0] OFS_OUT2 = 8'h14;    // Port two output latch.
  localparam logic [7:0] OFS_IN0  = 8'h18;    // Port zero pin levels.
  localparam logic [7:0] OFS_IN1  = 8'h1c;    // Port one pin levels.
  localparam logic [7:0] OFS_IN2  = 8'h20;    // Port two pin levels.
  localparam logic [7:0] OFS_PULL = 8'h24;    // Pull-up group enables.
  localparam logic [7:0] OFS_ADX  = 8'h28;    // Port zero analog select.
  localparam logic [7:0] OFS_IRQ  = 8'h2c;    // Interrupt pin select.
  localparam logic [7:0] OFS_CTRL = 8'h30;    // Mode and bus layout.
  localparam logic [7:0] OFS_STAT = 8'h34;    // Straps and mode status.

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_SEP_BIT = 2;            // Separate data bus enable.
  localparam int STAT_W16_BIT = 2;            // Sixteen-bit bus in use.
  localparam logic [7:0] RST_DIR  = 8'h00;    // All pins are inputs.
  localparam logic [7:0] RST_OUT  = 8'h00;
  localparam logic [7:0] RST_ADX  = 8'h00;
  localparam logic [5:0] RST_PULL = 6'h00;
  localparam logic [2:0] RST_IRQ  = 3'h0;
  localparam logic       RST_SEP  = 1'b0;

  // Processor modes; the numeric order is what software writes.
  typedef enum logic [1:0] {
    PBFS_SINGLE,
    PBFS_EXPAND,
    PBFS_MICRO
  } pbfs_mode_t;

endpackage : pbfs_pkg

// ==== core/pbfs_sync_if.sv ====
// Bundle carrying raw pin levels into the synchroniser and back out.
`timescale 1ns/1ps
interface pbfs_sync_if #(
  parameter int W = 27
) ();
  logic [W-1:0] raw;     // Levels straight from the pins.
  logic [W-1:0] synced;  // Levels after two flip-flops.
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : pbfs_sync_if

// ==== core/pbfs_sync.sv ====
// Two-stage synchroniser bank for pin and strap inputs.
`timescale 1ns/1ps
module pbfs_sync #(
  parameter int W = 27
) (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  pbfs_sync_if.sync   s
);

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  logic [W-1:0] meta_q;  // First stage, read only by the second.
  logic [W-1:0] sync_q;  // Second stage, safe for logic.

  // Both stages clear on reset so that the core sees a known level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= s.raw;
      sync_q <= meta_q;
    end
  end

  assign s.synced = sync_q;

endmodule : pbfs_sync

// ==== core/pbfs_top.sv ====
// Pin function selector for ports zero to two, mode straps and data bus.
`timescale 1ns/1ps
module pbfs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone register slave.
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Pins and straps.
  input  wire logic        reset_pin_n_i,
  input  wire logic        processor_mode_strap_i,
  input  wire logic        bus_width_strap_i,
  input  wire logic [23:0] pin_i,
  output logic [23:0]      pin_o,
  output logic [23:0]      pin_oe_o,
  output logic [23:0]      pin_pu_o,
  // Core side of the external data bus.
  input  wire logic [15:0] xbus_wdata_i,
  input  wire logic        xbus_drive_i,
  output logic [15:0]      xbus_rdata_o,
  output logic [1:0]       mode_o,
  output logic             bus_16bit_o,
  // Analog switch enables and interrupt request levels.
  output logic [7:0]       ad_ext_en_o,
  output logic [2:0]       ext_irq_o
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  pbfs_sync_if #(.W(pbfs_pkg::NSYNC)) sif ();

  assign sif.raw = {reset_pin_n_i, processor_mode_strap_i,
                    bus_width_strap_i, pin_i};

  pbfs_sync #(.W(pbfs_pkg::NSYNC)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .s     (sif)
  );

  logic [23:0] pin_s;     // Synchronised pin levels.
  logic        w8_s;      // Width strap: high selects the 8-bit bus.
  logic        pmode_s;   // Mode strap: high selects microprocessor mode.
  logic        rstpin_s;  // Reset pin, high when released.

  assign pin_s    = sif.synced[23:0];
  assign w8_s     = sif.synced[24];
  assign pmode_s  = sif.synced[25];
  assign rstpin_s = sif.synced[26];

  // ----------------------------------------------------------------------
  // Block reset
  // ----------------------------------------------------------------------
  logic core_rst_q;  // Combined bus reset and pin reset.

  // A low reset pin keeps every control register at its reset value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= ~rstpin_s;
    end
  end

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0]           dir_q [pbfs_pkg::NPORT];  // One bit per pin.
  logic [7:0]           out_q [pbfs_pkg::NPORT];  // Output latches.
  logic [5:0]           pull_q;                   // Nibble pull-ups.
  logic [7:0]           adx_q;                    // Analog selects.
  logic [2:0]           irqsel_q;                 // Interrupt selects.
  logic                 sep_q;                    // Separate bus on.
  pbfs_pkg::pbfs_mode_t mode_q;                   // Processor mode.
  logic                 single;                   // Single-chip mode.
  logic                 w16;                      // 16-bit bus chosen.
  logic                 wr_en;                    // Accepted write.

  assign single = (mode_q == pbfs_pkg::PBFS_SINGLE);
  // The width strap is only ever read through the synchroniser, so a
  // board that wiggles it still gives clean, if meaningless, levels.
  assign w16    = ~w8_s;
  assign wr_en  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

  // Control registers; only the low byte lane carries data.
  always_ff @(posedge clk_i) begin
    if (core_rst_q) begin
      dir_q    <= '{default: pbfs_pkg::RST_DIR};
      out_q    <= '{default: pbfs_pkg::RST_OUT};
      pull_q   <= pbfs_pkg::RST_PULL;
      adx_q    <= pbfs_pkg::RST_ADX;
      irqsel_q <= pbfs_pkg::RST_IRQ;
      sep_q    <= pbfs_pkg::RST_SEP;
    end else if (wr_en) begin
      case (wb_adr_i)
        pbfs_pkg::OFS_DIR0: dir_q[0] <= wb_dat_i[7:0];
        pbfs_pkg::OFS_DIR1: dir_q[1] <= wb_dat_i[7:0];
        pbfs_pkg::OFS_DIR2: dir_q[2] <= wb_dat_i[7:0];
        pbfs_pkg::OFS_OUT0: out_q[0] <= wb_dat_i[7:0];
        pbfs_pkg::OFS_OUT1: out_q[1] <= wb_dat_i[7:0];
        pbfs_pkg::OFS_OUT2: out_q[2] <= wb_dat_i[7:0];
        pbfs_pkg::OFS_PULL: pull_q   <= wb_dat_i[5:0];
        pbfs_pkg::OFS_ADX:  adx_q    <= wb_dat_i[7:0];
        pbfs_pkg::OFS_IRQ:  irqsel_q <= wb_dat_i[2:0];
        pbfs_pkg::OFS_CTRL: sep_q    <= wb_dat_i[pbfs_pkg::CTRL_SEP_BIT];
        default: ;  // Read-only or unmapped: the write is dropped.
      endcase
    end
  end

  // Mode starts from the strap; software may move it later. The reserved
  // code three is refused so the mode never leaves the legal set.
  always_ff @(posedge clk_i) begin
    if (core_rst_q) begin
      mode_q <= pmode_s ? pbfs_pkg::PBFS_MICRO
                        : pbfs_pkg::PBFS_SINGLE;
    end else if (wr_en && wb_adr_i == pbfs_pkg::OFS_CTRL
                 && wb_dat_i[1:0] != 2'h3) begin
      mode_q <= pbfs_pkg::pbfs_mode_t'(wb_dat_i[1:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------------------
  // True where a port is handed to the separate external data bus.
  function automatic logic bus_owns(input pbfs_pkg::pbfs_mode_t m,
                                    input logic sep, input logic wide,
                                    input int port);
    bus_owns = (m != pbfs_pkg::PBFS_SINGLE) && sep
               && (port == 0 || (port == 1 && wide));
  endfunction : bus_owns

  logic [23:0] nxt_o;   // Next pin output level.
  logic [23:0] nxt_oe;  // Next pin output enable.
  logic [23:0] nxt_pu;  // Next pull-up enable.
  logic [7:0]  nxt_adx; // Next analog switch enable.

  for (genvar g = 0; g < pbfs_pkg::PINS; g++) begin : g_pin
    localparam int P = g / pbfs_pkg::PORT_W;
    localparam int B = g % pbfs_pkg::PORT_W;
    logic own;   // Pin belongs to the data bus.
    logic adx;   // Pin is an analog input.
    logic irq;   // Pin is an interrupt input.
    // Port one carries the high byte only on a 16-bit bus.
    assign own = bus_owns(mode_q, sep_q, w16, P);
    // Analog use exists only on port zero and only in single-chip mode.
    if (P == 0) begin : g_adx
      assign adx = single & adx_q[B];
    end else begin : g_noadx
      assign adx = 1'b0;
    end
    if (P == 1 && B >= pbfs_pkg::IRQ_LSB) begin : g_irq
      assign irq = irqsel_q[B - pbfs_pkg::IRQ_LSB];
    end else begin : g_noirq
      assign irq = 1'b0;
    end
    // Bus-owned pins carry the data bus word; all other pins carry their output latch.
    assign nxt_o[g]  = own ? xbus_wdata_i[g % 16] : out_q[P][B];
    // Bus-owned ports follow xbus_drive_i; others their own direction bits, off on analog and interrupt pins.
    assign nxt_oe[g] = own ? xbus_drive_i
                           : (dir_q[P][B] & ~adx & ~irq);
    // Pull-ups act on plain inputs in single-chip mode only.
    assign nxt_pu[g] = single & ~own & ~adx & ~dir_q[P][B]
                       & pull_q[P * 2 + B / 4];
  end

  assign nxt_adx = adx_q & {8{single}};

  // All pin-facing outputs come from flip-flops; reset leaves every pin
  // undriven so straps and board pulls are not fought after power-up.
  always_ff @(posedge clk_i) begin
    if (core_rst_q) begin
      pin_o       <= '0;
      pin_oe_o    <= '0;
      pin_pu_o    <= '0;
      ad_ext_en_o <= '0;
      ext_irq_o   <= '0;
    end else begin
      pin_o       <= nxt_o;
      pin_oe_o    <= nxt_oe;
      pin_pu_o    <= nxt_pu;
      ad_ext_en_o <= nxt_adx;
      ext_irq_o   <= pin_s[15:13] & irqsel_q;
    end
  end

  // Read side of the data bus and mode reporting.
  always_ff @(posedge clk_i) begin
    if (core_rst_q) begin
      xbus_rdata_o <= '0;
      mode_o       <= 2'h0;
      bus_16bit_o  <= 1'b0;
    end else begin
      xbus_rdata_o <= {w16 ? pin_s[15:8] : 8'h00, pin_s[7:0]};
      mode_o       <= mode_q;
      bus_16bit_o  <= w16;
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  logic [31:0] rd_d;  // Read data for the addressed register.

  // Unmapped addresses read as zero but are still acknowledged.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      pbfs_pkg::OFS_DIR0: rd_d[7:0] = dir_q[0];
      pbfs_pkg::OFS_DIR1: rd_d[7:0] = dir_q[1];
      pbfs_pkg::OFS_DIR2: rd_d[7:0] = dir_q[2];
      pbfs_pkg::OFS_OUT0: rd_d[7:0] = out_q[0];
      pbfs_pkg::OFS_OUT1: rd_d[7:0] = out_q[1];
      pbfs_pkg::OFS_OUT2: rd_d[7:0] = out_q[2];
      pbfs_pkg::OFS_IN0:  rd_d[7:0] = pin_s[7:0];
      pbfs_pkg::OFS_IN1:  rd_d[7:0] = pin_s[15:8];
      pbfs_pkg::OFS_IN2:  rd_d[7:0] = pin_s[23:16];
      pbfs_pkg::OFS_PULL: rd_d[5:0] = pull_q;
      pbfs_pkg::OFS_ADX:  rd_d[7:0] = adx_q;
      pbfs_pkg::OFS_IRQ:  rd_d[2:0] = irqsel_q;
      pbfs_pkg::OFS_CTRL: rd_d[2:0] = {sep_q, mode_q};
      pbfs_pkg::OFS_STAT: rd_d[2:0] = {w16, mode_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // One wait state: ack rises one edge after the request and drops next.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (core_rst_q);

  a_mode_strap_start: assert property (
    $fell(core_rst_q) |-> mode_q == ($past(pmode_s)
      ? pbfs_pkg::PBFS_MICRO : pbfs_pkg::PBFS_SINGLE))
    else $error("mode after reset does not match strap");

  a_reset_pin_hold: assert property (
    disable iff (rst_i) !rstpin_s |-> ##2 (pin_oe_o == 24'h0))
    else $error("pins driven while reset pin low");

  a_narrow_high_zero: assert property (
    w8_s |=> xbus_rdata_o[15:8] == 8'h00)
    else $error("high data byte seen on 8-bit bus");

  a_port0_dir_follow: assert property (
    (single && adx_q == 8'h00) |=> pin_oe_o[7:0] == $past(dir_q[0]))
    else $error("port zero direction not followed");

  a_pull_single_on: assert property (
    (single && dir_q[0] == 8'h00 && adx_q == 8'h00)
      |=> pin_pu_o[3:0] == {4{$past(pull_q[0])}})
    else $error("port zero pull-up group wrong");

  a_pull_other_off: assert property (
    !single |=> pin_pu_o == 24'h0)
    else $error("pull-up active outside single-chip mode");

  a_adx_undriven: assert property (
    (single && adx_q[0]) |=> !pin_oe_o[0] && ad_ext_en_o[0])
    else $error("analog pin driven or switch off");

  a_low_byte_bus: assert property (
    (!single && sep_q && xbus_drive_i) |=> pin_oe_o[7:0] == 8'hff
      && pin_o[7:0] == $past(xbus_wdata_i[7:0]))
    else $error("low data byte not on port zero");

  a_port2_dir_follow: assert property (
    1'b1 |=> pin_oe_o[23:16] == $past(dir_q[2]))
    else $error("port two direction not followed");

  a_irq_pin_input: assert property (
    (irqsel_q[0] && !(sep_q && !single && w16)) |=> !pin_oe_o[13])
    else $error("interrupt pin driven");

  a_high_byte_bus: assert property (
    (!single && sep_q && w16 && xbus_drive_i)
      |=> pin_o[15:8] == $past(xbus_wdata_i[15:8]))
    else $error("high data byte not on port one");

  a_narrow_gpio_p1: assert property (
    (w8_s && irqsel_q == 3'h0) |=> pin_oe_o[15:8] == $past(dir_q[1]))
    else $error("port one not a plain port on 8-bit bus");

  c_micro_start: cover property ($fell(core_rst_q) && !single);
  c_wide_bus_wr: cover property (!single && sep_q && w16 && xbus_drive_i);
  c_irq_selected: cover property (ext_irq_o != 3'h0);
  c_analog_on: cover property (ad_ext_en_o != 8'h00);

endmodule : pbfs_top

// ==== bench/pbfs_board_model.sv ====
// Board and external devices that share the port pins with the block.
`timescale 1ns/1ps
module pbfs_board_model (
  input  wire logic        clk_i,
  input  wire logic [23:0] pin_o_i,
  input  wire logic [23:0] pin_oe_i,
  input  wire logic [23:0] pin_pu_i,
  input  wire logic [23:0] ext_val_i,
  input  wire logic [23:0] ext_en_i,
  output logic      [23:0] pin_level_o
);
  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  logic [23:0] last_q = 24'h000000;  // Level seen on the previous cycle.

  // The device wins, then the board, then a pull-up. A pin nobody drives
  // flips every cycle, so a stale level can never pass for real data.
  assign pin_level_o = (pin_oe_i & pin_o_i)
                     | (~pin_oe_i & ext_en_i & ext_val_i)
                     | (~pin_oe_i & ~ext_en_i & (pin_pu_i | ~last_q));

  // Remember the resolved level for the floating-pin pattern.
  always @(posedge clk_i) begin
    last_q <= pin_level_o;
  end
endmodule : pbfs_board_model

// ==== bench/pbfs_top_tb.sv ====
// Self-checking bench for the port and bus pin function selector.
`timescale 1ns/1ps
module pbfs_top_tb;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        wb_we_i = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        reset_pin_n_i = 1'b1;
  logic        mode_strap = 1'b0;      // Starts low; raised while the reset pin is low.
  logic        width_strap = 1'b0;     // Held steady while running.
  logic [15:0] xbus_wdata_i = 16'h0000;
  logic        xbus_drive_i = 1'b0;
  logic [23:0] ext_val = 24'h000000;   // Levels the board puts on pins.
  logic [23:0] ext_en = 24'h000000;    // Pins the board drives.
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [23:0] pin_i, pin_o, pin_oe_o, pin_pu_o;
  logic [15:0] xbus_rdata_o;
  logic [1:0]  mode_o;
  logic        bus_16bit_o;
  logic [7:0]  ad_ext_en_o;
  logic [2:0]  ext_irq_o;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc_cnt = 0;

  always #5 clk_i = ~clk_i;

  pbfs_top u_pbfs_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reset_pin_n_i(reset_pin_n_i), .processor_mode_strap_i(mode_strap),
    .bus_width_strap_i(width_strap), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .xbus_wdata_i(xbus_wdata_i),
    .xbus_drive_i(xbus_drive_i), .xbus_rdata_o(xbus_rdata_o),
    .mode_o(mode_o), .bus_16bit_o(bus_16bit_o), .ad_ext_en_o(ad_ext_en_o),
    .ext_irq_o(ext_irq_o));

  pbfs_board_model u_pbfs_board_model (
    .clk_i(clk_i),
    .pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pin_pu_i(pin_pu_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_level_o(pin_i));

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  // One classic cycle: the request is held until the rising edge at which
  // ack is sampled high; data is taken and the request dropped there.
  task automatic wb_io(input logic we, input logic [7:0] adr,
                       input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, wd};
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_io

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [31:0] unused;
    wb_io(1'b1, adr, d, unused);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    wb_io(1'b0, adr, 8'h00, got);
    chk(got, exp);
  endtask : rd_chk

  // Let a fixed number of cycles pass; outputs are sampled mid-cycle.
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle

  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Cuts a hang short; the whole sequence needs fewer than 150 cycles.
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    idle(6);
    chk(32'(mode_o), 32'(pbfs_pkg::PBFS_SINGLE));
    chk(32'(bus_16bit_o), 32'h00000001);
    rd_chk(pbfs_pkg::OFS_STAT, 32'h00000004);
    rd_chk(pbfs_pkg::OFS_DIR0, 32'h00000000);
    rd_chk(8'h3c, 32'h00000000);
    wr(pbfs_pkg::OFS_DIR0, 8'h0f);
    wr(pbfs_pkg::OFS_OUT0, 8'ha5);
    wr(pbfs_pkg::OFS_DIR1, 8'hff);
    wr(pbfs_pkg::OFS_OUT1, 8'h3c);
    wr(pbfs_pkg::OFS_DIR2, 8'hf0);
    wr(pbfs_pkg::OFS_OUT2, 8'hc3);
    wr(pbfs_pkg::OFS_PULL, 8'h3f);
    idle(2);
    chk(32'(pin_oe_o), 32'h00f0ff0f);
    chk(32'(pin_o & pin_oe_o), 32'h00c03c05);
    chk(32'(pin_pu_o), 32'h000f00f0);
    // Analog select overrides direction and pull-up on those pins.
    wr(pbfs_pkg::OFS_ADX, 8'h81);
    idle(2);
    chk(32'(ad_ext_en_o), 32'h00000081);
    chk(32'(pin_oe_o[7:0]), 32'h0000000e);
    chk(32'(pin_pu_o[7:0]), 32'h00000070);
    // The board drives the three interrupt-capable bits with 101.
    @(posedge clk_i);
    ext_en  <= 24'h00e000;
    ext_val <= 24'h00a000;
    wr(pbfs_pkg::OFS_IRQ, 8'h07);
    idle(5);
    chk(32'(ext_irq_o), 32'h00000005);
    chk(32'(pin_oe_o[15:8]), 32'h0000001f);
    wr(pbfs_pkg::OFS_CTRL, 8'h01);
    idle(2);
    chk(32'(pin_pu_o), 32'h00000000);
    // Separate bus, sixteen bits: write phase, then a read phase.
    @(posedge clk_i);
    ext_en       <= 24'h000000;
    xbus_wdata_i <= 16'h3c5a;
    xbus_drive_i <= 1'b1;
    wr(pbfs_pkg::OFS_CTRL, 8'h05);
    idle(2);
    chk(32'(pin_oe_o[15:0]), 32'h0000ffff);
    chk(32'(pin_o[15:0]), 32'h00003c5a);
    @(posedge clk_i);
    xbus_drive_i <= 1'b0;
    ext_en       <= 24'h00ffff;
    ext_val      <= 24'h00a55a;
    idle(5);
    chk(32'(xbus_rdata_o), 32'h0000a55a);
    rd_chk(pbfs_pkg::OFS_IN1, 32'h000000a5);
    // Reset pin low releases every pin; straps move only inside reset.
    @(posedge clk_i);
    reset_pin_n_i <= 1'b0;
    ext_en        <= 24'h000000;
    idle(5);
    chk(32'(pin_oe_o), 32'h00000000);
    @(posedge clk_i);
    mode_strap  <= 1'b1;
    width_strap <= 1'b1;
    idle(8);
    @(posedge clk_i);
    reset_pin_n_i <= 1'b1;
    idle(6);
    chk(32'(mode_o), 32'(pbfs_pkg::PBFS_MICRO));
    chk(32'(bus_16bit_o), 32'h00000000);
    wr(pbfs_pkg::OFS_PULL, 8'h3f);
    idle(2);
    chk(32'(pin_pu_o), 32'h00000000);
    // Eight-bit bus: port one stays a general port.
    @(posedge clk_i);
    xbus_drive_i <= 1'b1;
    wr(pbfs_pkg::OFS_DIR1, 8'h33);
    wr(pbfs_pkg::OFS_CTRL, 8'h06);
    idle(2);
    chk(32'(pin_oe_o[15:0]), 32'h000033ff);
    chk(32'(pin_o[7:0]), 32'h0000005a);
    @(posedge clk_i);
    xbus_drive_i <= 1'b0;
    ext_en       <= 24'h00ffff;
    idle(5);
    chk(32'(xbus_rdata_o), 32'h0000005a);
    report_and_stop();
  end
endmodule : pbfs_top_tb
